// file: logic/oot_chan.sv
`timescale 1ns/1ps
`default_nettype none
module oot_chan (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// software writes
	input wire logic ctrl_we,
	input wire logic trim_we,
	input wire logic [7:0] wdata,
	// search engine writes
	input wire logic eng_we,
	input wire logic [5:0] eng_trim,
	// amplifier side
	input wire logic cmp_in,
	output logic amp_en,
	output logic [1:0] amp_bw,
	output logic cal_mode_select,
	output logic cal_ref_select,
	output logic [5:0] trim_code,
	output logic amp_output_status
);
	typedef struct packed {
		logic en;
		logic [1:0] bw;
		logic mode;
		logic rsel;
		logic [5:0] trim;
		logic stat;
	} oot_chst_t;
	oot_chst_t st_ff, nxt_st;
	// ==========================================
	// next state
	always_comb begin
		nxt_st = st_ff;
		if (ctrl_we) begin
			nxt_st.en = wdata[oot_pkg::CTRL_EN_BIT];
			nxt_st.bw = wdata[oot_pkg::CTRL_BW_LSB +: 2];
		end
		if (eng_we) begin
			nxt_st.mode = 1'b1;
			nxt_st.rsel = 1'b1;
			nxt_st.trim = eng_trim;
		end else if (trim_we) begin
			nxt_st.mode = wdata[oot_pkg::TRIM_MODE_BIT];
			nxt_st.rsel = wdata[oot_pkg::TRIM_REF_BIT];
			nxt_st.trim = wdata[oot_pkg::TRIM_CODE_LSB +: oot_pkg::TRIM_W];
		end
		nxt_st.stat = st_ff.mode & cmp_in;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '{en: 1'b0, bw: 2'h0, mode: 1'b0, rsel: 1'b0,
				trim: oot_pkg::TRIM_CODE_RST, stat: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign amp_en = st_ff.en;
	assign amp_bw = st_ff.bw;
	assign cal_mode_select = st_ff.mode;
	assign cal_ref_select = st_ff.rsel;
	assign trim_code = st_ff.trim;
	assign amp_output_status = st_ff.stat;
	// ==========================================
	// checks
	stat_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(st_ff.mode) |-> !amp_output_status) else $error("status not low outside cal");
	trim_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		trim_we && !eng_we |=> trim_code == $past(wdata[5:0])) else $error("trim write lost");
	eng_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		eng_we |=> cal_mode_select && cal_ref_select && trim_code == $past(eng_trim))
		else $error("engine write did not enter cal mode");
endmodule
`default_nettype wire

// file: logic/oot_pkg.sv
`default_nettype none
package oot_pkg;
	// ==========================================
	// register map, byte addresses
	localparam logic [7:0] A0_CTRL_OFS = 8'h00;
	localparam logic [7:0] A0_TRIM_OFS = 8'h04;
	localparam logic [7:0] A1_CTRL_OFS = 8'h08;
	localparam logic [7:0] A1_TRIM_OFS = 8'h0c;
	localparam logic [7:0] CAL_CTRL_OFS = 8'h10;
	localparam logic [7:0] CAL_STAT_OFS = 8'h14;
	// ==========================================
	// control register fields
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_STAT_BIT = 5;
	localparam int CTRL_BW_LSB = 0;
	// ==========================================
	// trim register fields
	localparam int TRIM_MODE_BIT = 7;
	localparam int TRIM_REF_BIT = 6;
	localparam int TRIM_CODE_LSB = 0;
	localparam int TRIM_W = 6;
	localparam logic [5:0] TRIM_CODE_RST = 6'h20;
	localparam logic [5:0] TRIM_ZERO = 6'h00;
	localparam logic [5:0] TRIM_ONES = 6'h3f;
	// ==========================================
	// search engine control and status fields
	localparam int CAL_START_BIT = 0;
	localparam int CAL_SEL_BIT = 1;
	localparam int CAL_SETTLE_LSB = 8;
	localparam int SETTLE_W = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_LOW_LSB = 8;
	localparam int STAT_UP_LSB = 16;
	// ==========================================
	// settling time after a trim update
	localparam int CLK_MHZ = 200;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [15:0] SETTLE_RST = 16'(SETTLE_CYC);
	// ==========================================
	// ahb constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum {S_IDLE, S_WAIT} oot_sst_t;
endpackage
`default_nettype wire

// file: logic/oot_search.sv
`timescale 1ns/1ps
`default_nettype none
module oot_search (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// control side
	oot_srch_if.eng sif
);
	typedef struct packed {
		oot_pkg::oot_sst_t sm;
		logic down;
		logic first;
		logic refv;
		logic [15:0] cnt;
		logic [5:0] code;
		logic [5:0] lower;
		logic [5:0] upper;
		logic we;
		logic done;
	} oot_sest_t;
	oot_sest_t st_ff, nxt_st;
	logic [6:0] sum;
	// ==========================================
	// search sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_st.we = 1'b0;
		sum = {1'b0, st_ff.lower} + {1'b0, st_ff.code};
		case (st_ff.sm)
			oot_pkg::S_IDLE: begin
				if (sif.start) begin
					nxt_st.sm = oot_pkg::S_WAIT;
					nxt_st.down = 1'b0;
					nxt_st.first = 1'b1;
					nxt_st.code = oot_pkg::TRIM_ZERO;
					nxt_st.cnt = sif.settle;
					nxt_st.we = 1'b1;
					nxt_st.done = 1'b0;
				end
			end
			oot_pkg::S_WAIT: begin
				if (st_ff.cnt != 16'h0000) begin
					nxt_st.cnt = st_ff.cnt - 16'h0001;
				end else if (st_ff.first) begin
					nxt_st.first = 1'b0;
					nxt_st.refv = sif.status;
				end else if (sif.status != st_ff.refv ||
					st_ff.code == (st_ff.down ? oot_pkg::TRIM_ZERO : oot_pkg::TRIM_ONES)) begin
					if (!st_ff.down) begin
						nxt_st.lower = st_ff.code;
						nxt_st.down = 1'b1;
						nxt_st.first = 1'b1;
						nxt_st.code = oot_pkg::TRIM_ONES;
						nxt_st.cnt = sif.settle;
						nxt_st.we = 1'b1;
					end else begin
						nxt_st.upper = st_ff.code;
						nxt_st.code = sum[6:1];
						nxt_st.we = 1'b1;
						nxt_st.done = 1'b1;
						nxt_st.sm = oot_pkg::S_IDLE;
					end
				end else begin
					nxt_st.code = st_ff.down ? st_ff.code - 6'h01 : st_ff.code + 6'h01;
					nxt_st.cnt = sif.settle;
					nxt_st.we = 1'b1;
				end
			end
			default: nxt_st.sm = oot_pkg::S_IDLE;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '{sm: oot_pkg::S_IDLE, down: 1'b0, first: 1'b0, refv: 1'b0, cnt: 16'h0000,
				code: oot_pkg::TRIM_ZERO, lower: 6'h00, upper: 6'h00, we: 1'b0, done: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign sif.busy = (st_ff.sm != oot_pkg::S_IDLE);
	assign sif.done = st_ff.done;
	assign sif.trim_we = st_ff.we;
	assign sif.trim_val = st_ff.code;
	assign sif.lower = st_ff.lower;
	assign sif.upper = st_ff.upper;
	// ==========================================
	// checks
	sequence start_seq;
		!sif.busy && sif.start;
	endsequence
	start_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start_seq |=> sif.trim_we && sif.trim_val == 6'h00 && sif.busy) else $error("bad start");
	final_avg_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(sif.done) |-> sif.trim_we &&
		sif.trim_val == 6'((7'(sif.lower) + 7'(sif.upper)) >> 1)) else $error("bad average");
	settle_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sif.trim_we && sif.busy && sif.settle == 16'h0003 |=> !sif.trim_we [*3])
		else $error("sampled before settling");
endmodule
`default_nettype wire

// file: logic/oot_srch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface oot_srch_if;
	logic start;
	logic [15:0] settle;
	logic status;
	logic busy;
	logic done;
	logic trim_we;
	logic [5:0] trim_val;
	logic [5:0] lower;
	logic [5:0] upper;
	modport ctl (output start, output settle, output status, input busy, input done,
		input trim_we, input trim_val, input lower, input upper);
	modport eng (input start, input settle, input status, output busy, output done,
		output trim_we, output trim_val, output lower, output upper);
endinterface
`default_nettype wire

// file: logic/oot_top.sv
// Function
// - trim bit 7 picks normal amplification or offset calibration mode
// - trim bit 6 picks calibration reference: inverting or non-inverting input
// - trim bits 5..0 drive offset correction, writable any time except a cycle the search engine writes that amplifier, keep restored value
// - two independent amplifiers, each enabled or disabled by software
// - output status bit follows amplifier only in calibration mode, else low
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module oot_top #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// amplifier zero
	input wire logic amp0_cmp,
	output logic amp0_en,
	output logic [1:0] amp0_bw,
	output logic amp0_cal_mode_select,
	output logic amp0_cal_ref_select,
	output logic [5:0] amp0_trim_code,
	// amplifier one
	input wire logic amp1_cmp,
	output logic amp1_en,
	output logic [1:0] amp1_bw,
	output logic amp1_cal_mode_select,
	output logic amp1_cal_ref_select,
	output logic [5:0] amp1_trim_code
);
	typedef struct packed {
		logic wpend;
		logic [7:0] waddr;
		logic rpend;
		logic [7:0] raddr;
		logic rdy;
		logic [31:0] rdata;
		logic start;
		logic sel;
		logic [15:0] settle;
	} oot_bst_t;
	oot_bst_t st_ff, nxt_st;
	oot_srch_if sif ();
	logic [7:0] wbyte;
	logic [7:0] rd_ctrl0, rd_ctrl1, rd_trim0, rd_trim1;
	logic stat0, stat1;
	logic take;

	// ==========================================
	// helpers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic [7:0] ctrl_val(input logic en, input logic st, input logic [1:0] bw);
		ctrl_val = 8'h00;
		ctrl_val[oot_pkg::CTRL_EN_BIT] = en;
		ctrl_val[oot_pkg::CTRL_STAT_BIT] = st;
		ctrl_val[oot_pkg::CTRL_BW_LSB +: 2] = bw;
	endfunction

	function automatic logic [7:0] trim_val(input logic m, input logic r, input logic [5:0] c);
		trim_val = {m, r, c};
	endfunction

	// ==========================================
	// amplifier channels
	oot_chan u_amp0 (
		.hclk(hclk),
		.hresetn(hresetn),
		.ctrl_we(st_ff.wpend && hit(st_ff.waddr, oot_pkg::A0_CTRL_OFS)),
		.trim_we(st_ff.wpend && hit(st_ff.waddr, oot_pkg::A0_TRIM_OFS)),
		.wdata(wbyte),
		.eng_we(sif.trim_we && !st_ff.sel),
		.eng_trim(sif.trim_val),
		.cmp_in(amp0_cmp),
		.amp_en(amp0_en),
		.amp_bw(amp0_bw),
		.cal_mode_select(amp0_cal_mode_select),
		.cal_ref_select(amp0_cal_ref_select),
		.trim_code(amp0_trim_code),
		.amp_output_status(stat0)
	);

	oot_chan u_amp1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.ctrl_we(st_ff.wpend && hit(st_ff.waddr, oot_pkg::A1_CTRL_OFS)),
		.trim_we(st_ff.wpend && hit(st_ff.waddr, oot_pkg::A1_TRIM_OFS)),
		.wdata(wbyte),
		.eng_we(sif.trim_we && st_ff.sel),
		.eng_trim(sif.trim_val),
		.cmp_in(amp1_cmp),
		.amp_en(amp1_en),
		.amp_bw(amp1_bw),
		.cal_mode_select(amp1_cal_mode_select),
		.cal_ref_select(amp1_cal_ref_select),
		.trim_code(amp1_trim_code),
		.amp_output_status(stat1)
	);

	// ==========================================
	// search engine
	oot_search u_search (
		.hclk(hclk),
		.hresetn(hresetn),
		.sif(sif.eng)
	);

	assign sif.start = st_ff.start;
	assign sif.settle = st_ff.settle;
	assign sif.status = st_ff.sel ? stat1 : stat0;

	// ==========================================
	// register read views
	assign wbyte = hwdata[7:0];
	assign rd_ctrl0 = ctrl_val(amp0_en, stat0, amp0_bw);
	assign rd_ctrl1 = ctrl_val(amp1_en, stat1, amp1_bw);
	assign rd_trim0 = trim_val(amp0_cal_mode_select, amp0_cal_ref_select, amp0_trim_code);
	assign rd_trim1 = trim_val(amp1_cal_mode_select, amp1_cal_ref_select, amp1_trim_code);

	function automatic logic [31:0] read_reg(input logic [7:0] a);
		read_reg = 32'h0000_0000;
		if (hit(a, oot_pkg::A0_CTRL_OFS)) begin
			read_reg[7:0] = rd_ctrl0;
		end else if (hit(a, oot_pkg::A0_TRIM_OFS)) begin
			read_reg[7:0] = rd_trim0;
		end else if (hit(a, oot_pkg::A1_CTRL_OFS)) begin
			read_reg[7:0] = rd_ctrl1;
		end else if (hit(a, oot_pkg::A1_TRIM_OFS)) begin
			read_reg[7:0] = rd_trim1;
		end else if (hit(a, oot_pkg::CAL_CTRL_OFS)) begin
			read_reg[oot_pkg::CAL_SEL_BIT] = st_ff.sel;
			read_reg[oot_pkg::CAL_SETTLE_LSB +: oot_pkg::SETTLE_W] = st_ff.settle;
		end else if (hit(a, oot_pkg::CAL_STAT_OFS)) begin
			read_reg[oot_pkg::STAT_BUSY_BIT] = sif.busy;
			read_reg[oot_pkg::STAT_DONE_BIT] = sif.done;
			read_reg[oot_pkg::STAT_LOW_LSB +: oot_pkg::TRIM_W] = sif.lower;
			read_reg[oot_pkg::STAT_UP_LSB +: oot_pkg::TRIM_W] = sif.upper;
		end
	endfunction

	// ==========================================
	// bus slave: writes zero wait, reads one wait state
	assign take = hsel && hready && htrans[1];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.start = 1'b0;
		nxt_st.wpend = 1'b0;
		nxt_st.rpend = 1'b0;
		nxt_st.rdy = 1'b1;
		if (st_ff.wpend && hit(st_ff.waddr, oot_pkg::CAL_CTRL_OFS)) begin
			if (!sif.busy) begin
				nxt_st.sel = hwdata[oot_pkg::CAL_SEL_BIT];
				nxt_st.start = hwdata[oot_pkg::CAL_START_BIT];
			end
			nxt_st.settle = hwdata[oot_pkg::CAL_SETTLE_LSB +: oot_pkg::SETTLE_W];
		end
		if (st_ff.rpend) begin
			nxt_st.rdata = read_reg(st_ff.raddr);
		end
		if (take) begin
			if (hwrite) begin
				nxt_st.wpend = 1'b1;
				nxt_st.waddr = 8'(haddr);
			end else begin
				nxt_st.rpend = 1'b1;
				nxt_st.raddr = 8'(haddr);
				nxt_st.rdy = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '{wpend: 1'b0, waddr: 8'h00, rpend: 1'b0, raddr: 8'h00, rdy: 1'b1,
				rdata: 32'h0000_0000, start: 1'b0, sel: 1'b0, settle: oot_pkg::SETTLE_RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hreadyout = st_ff.rdy;
	assign hrdata = st_ff.rdata;
	assign hresp = 1'b0;

	// ==========================================
	// checks
	sequence rd_addr_seq;
		take && !hwrite;
	endsequence

	sequence rd_data_seq;
		!hreadyout ##1 hreadyout;
	endsequence

	rd_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_addr_seq |=> rd_data_seq) else $error("read wait state wrong");
	trim_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(rd_addr_seq and haddr == ADDR_W'(oot_pkg::A0_TRIM_OFS)) ##1 !hreadyout
		|=> hrdata[7:0] == $past({amp0_cal_mode_select, amp0_cal_ref_select, amp0_trim_code}))
		else $error("trim readback wrong");
	en_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_ff.wpend && st_ff.waddr == oot_pkg::A1_CTRL_OFS |=> amp1_en == $past(hwdata[6]))
		else $error("enable write lost");
	busy_cal_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sif.busy && $past(sif.trim_we) && !st_ff.sel |-> amp0_cal_mode_select && amp0_cal_ref_select)
		else $error("search ran outside cal mode");
	okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hresp == 1'b0) else $error("non okay response");
endmodule
`default_nettype wire

// file: verif/oot_amp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// behavioural amplifier comparator
module oot_amp_model (
	// amplifier controls
	input wire logic en,
	input wire logic cal_ref,
	input wire logic [5:0] trim,
	// offset of this part, as a trim code
	input wire logic [5:0] thr,
	// comparator output
	output logic cmp
);
	// output flips where the trim code crosses the offset; low while disabled
	assign cmp = en & (cal_ref ? (trim >= thr) : (trim < thr));
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ==========================================
	// signals
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic amp0_cmp, amp0_en, amp0_cal_mode_select, amp0_cal_ref_select;
	logic amp1_cmp, amp1_en, amp1_cal_mode_select, amp1_cal_ref_select;
	logic [1:0] amp0_bw, amp1_bw;
	logic [5:0] amp0_trim_code, amp1_trim_code;
	logic [5:0] thr0 = 6'h00;
	logic [5:0] thr1 = 6'h00;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int seed = 93;

	always #2.5 hclk = ~hclk;

	// ==========================================
	// design and amplifier models
	oot_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.amp0_cmp(amp0_cmp), .amp0_en(amp0_en), .amp0_bw(amp0_bw),
		.amp0_cal_mode_select(amp0_cal_mode_select),
		.amp0_cal_ref_select(amp0_cal_ref_select), .amp0_trim_code(amp0_trim_code),
		.amp1_cmp(amp1_cmp), .amp1_en(amp1_en), .amp1_bw(amp1_bw),
		.amp1_cal_mode_select(amp1_cal_mode_select),
		.amp1_cal_ref_select(amp1_cal_ref_select), .amp1_trim_code(amp1_trim_code));
	oot_amp_model u_amp0 (.en(amp0_en), .cal_ref(amp0_cal_ref_select),
		.trim(amp0_trim_code), .thr(thr0), .cmp(amp0_cmp));
	oot_amp_model u_amp1 (.en(amp1_en), .cal_ref(amp1_cal_ref_select),
		.trim(amp1_trim_code), .thr(thr1), .cmp(amp1_cmp));

	// ==========================================
	// checking and bus tasks
	task automatic print_verdict();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= oot_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= oot_pkg::HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		if (wr) hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input int d);
		logic [31:0] x;
		bus(1'b1, a, 32'(d), x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	// ==========================================
	// reference model of comparator and search
	function automatic int cmpf(int rf, int t, int th);
		return rf ? int'(t >= th) : int'(t < th);
	endfunction

	function automatic int sweep(int th, int up);
		int r;
		int c;
		r = cmpf(1, up ? 0 : 63, th);
		for (int i = 1; i < 64; i++) begin
			c = up ? i : 63 - i;
			if (cmpf(1, c, th) != r) return c;
		end
		return up ? 63 : 0;
	endfunction

	// ==========================================
	// timeout
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		logic [31:0] d;
		int v, n, lo, hi, fin;
		int th [$];
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int k = 0; k < 2; k++) begin
			rd(8'(k * 8), d);
			chk("ctrl reset", d, 32'h0);
			rd(8'(k * 8 + 4), d);
			chk("trim reset", d, 32'h20);
		end
		chk("trim pins reset", 32'({amp1_trim_code, amp0_trim_code}), 32'h820);
		for (int k = 0; k < 2; k++) begin
			v = $random(seed) & 3;
			wr(8'(k * 8), 32'h40 | v);
			rd(8'(k * 8), d);
			chk("ctrl rw", d, 32'h40 | v);
			chk("en pins", 32'({amp1_en, amp0_en}), k ? 3 : 1);
			chk("bw pin", 32'(k ? amp1_bw : amp0_bw), v);
		end
		for (int k = 0; k < 8; k++) begin
			n = k / 4;
			v = ((k % 4) << 6) | ($random(seed) & 63);
			wr(8'(n * 8 + 4), v);
			rd(8'(n * 8 + 4), d);
			chk("trim rw", d, v);
			chk("mode pin", 32'(n ? amp1_cal_mode_select : amp0_cal_mode_select), v >> 7);
			chk("ref pin", 32'(n ? amp1_cal_ref_select : amp0_cal_ref_select), (v >> 6) & 1);
			chk("code pin", 32'(n ? amp1_trim_code : amp0_trim_code), v & 63);
		end
		thr0 <= 6'h10;
		for (int k = 0; k < 4; k++) begin
			v = (k & 1) ? 24 : 8;
			wr(oot_pkg::A0_TRIM_OFS, ((k >> 1) << 7) | 32'h40 | v);
			repeat (2) @(posedge hclk);
			rd(oot_pkg::A0_CTRL_OFS, d);
			chk("status bit", 32'(d[5]), (k >> 1) & cmpf(1, v, 16));
		end
		wr(8'h18, 32'hffff_ffff);
		rd(8'h18, d);
		chk("unmapped", d, 32'h0);
		chk("hresp", 32'(hresp), 32'h0);
		th = {0, 63, $random(seed) & 63, $random(seed) & 63};
		for (int k = 0; k < 4; k++) begin
			n = k & 1;
			if (n) thr1 <= 6'(th[k]);
			else thr0 <= 6'(th[k]);
			wr(oot_pkg::CAL_CTRL_OFS, (3 << 8) | (n << 1) | 1);
			repeat (2) @(posedge hclk);
			rd(oot_pkg::CAL_CTRL_OFS, d);
			chk("settle field", d, (3 << 8) | (n << 1));
			rd(oot_pkg::CAL_STAT_OFS, d);
			chk("busy", 32'(d[1:0]), 1);
			v = 0;
			do begin
				rd(oot_pkg::CAL_STAT_OFS, d);
				v++;
			end while (d[1] !== 1'b1 && v < 1000);
			lo = sweep(th[k], 1);
			hi = sweep(th[k], 0);
			fin = (lo + hi) / 2;
			chk("crossings", d, (hi << 16) | (lo << 8) | 2);
			rd(8'(n * 8 + 4), d);
			chk("final trim", d, 32'hc0 | fin);
			v = $random(seed) & 63;
			wr(8'(n * 8 + 4), v);
			rd(8'(n * 8 + 4), d);
			chk("restore", d, v);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
